/* File: linear_encoder_homing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "homing_cfg.svh"

module linear_encoder_homing
	import homing_pkg::*;
#(
	parameter int POS_W = `POS_W
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [POS_W-1:0] feedback_pos,
	input wire logic encoder_index,
	input wire logic proximity_dog,
	input wire logic [`STOP_SEL_W-1:0] linear_motor_function_select,
	input wire logic homing_stop_position_select,
	input wire logic multipoint_index_select,
	input wire logic serial_incremental_encoder,
	input wire logic [`METHOD_W-1:0] homing_method,
	input wire logic [POS_W-1:0] home_shift_distance,
	input wire logic [POS_W-1:0] home_shift_distance_extension,
	input wire logic home_start,
	output logic encoder_index_pulse_output,
	output logic homing_direction_negative,
	output logic homing_busy,
	output logic homing_done,
	output logic homing_error,
	output logic restricted_region,
	output logic index_passed,
	output logic [POS_W-1:0] home_position,
	output logic [POS_W-1:0] target_position,
	output logic target_valid
);
	// =========================================
	// Parameter check
	if (POS_W < 27)
	begin : g_pos_w_check
		$error("POS_W too narrow for the largest stop interval");
	end

	// =========================================
	// Pin synchronisers
	logic [1:0] index_sync_q;
	logic [1:0] dog_sync_q;
	logic index_prev_q;
	logic dog_prev_q;
	logic index_rise;
	logic dog_fall;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			index_sync_q <= 2'h0;
			dog_sync_q <= 2'h0;
			index_prev_q <= 1'b0;
			dog_prev_q <= 1'b0;
		end
		else
		begin
			index_sync_q <= {index_sync_q[0], encoder_index};
			dog_sync_q <= {dog_sync_q[0], proximity_dog};
			index_prev_q <= index_sync_q[1];
			dog_prev_q <= dog_sync_q[1];
		end
	end

	assign index_rise = index_sync_q[1] & ~index_prev_q;
	assign dog_fall = ~dog_sync_q[1] & dog_prev_q;

	// =========================================
	// Stop interval, held to the reset default until set
	logic [`STOP_SEL_W-1:0] stop_sel_q;
	logic [POS_W-1:0] interval;
	logic [31:0] interval_raw;
	logic sel_valid;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stop_sel_q <= `STOP_SEL_RESET;
		else if (sel_valid)
			stop_sel_q <= linear_motor_function_select;
	end

	stop_interval_lut u_lut
	(
		.sel(linear_motor_function_select),
		.interval(),
		.valid(sel_valid)
	);

	stop_interval_lut u_lut_q
	(
		.sel(stop_sel_q),
		.interval(interval_raw),
		.valid()
	);

	assign interval = POS_W'(interval_raw);

	// =========================================
	// Method decode
	function automatic logic method_known(input logic [`METHOD_W-1:0] m);
		method_known = (m == `METHOD_33) || (m == `METHOD_34) ||
			(m == `METHOD_M11) || (m == `METHOD_M43);
	endfunction

	// 34 and -11 run forward; 33 and -43 mirror them
	function automatic logic method_reversed(input logic [`METHOD_W-1:0] m);
		method_reversed = (m == `METHOD_33) || (m == `METHOD_M43);
	endfunction

	// =========================================
	// Index anchor
	logic [POS_W-1:0] anchor_q;
	logic [POS_W-1:0] shift;
	logic [POS_W-1:0] offset;
	logic [POS_W-1:0] below;
	logic [POS_W-1:0] above;
	logic [POS_W-1:0] nearest;
	logic stop_at_index;
	logic reversed_q;
	logic running;
	logic start_accept;
	homing_state_type state_q;

	// From the state: the busy flop lags, a start just after done would miss the clear
	assign running = (state_q == st_seek_dog) || (state_q == st_in_dog) ||
		(state_q == st_seek_target);
	assign start_accept = home_start && !running;

	// Multipoint: every mark re-anchors; else only the first in a run
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			anchor_q <= '0;
			index_passed <= 1'b0;
		end
		else if (start_accept)
			index_passed <= 1'b0;
		else if (index_rise && running && (!index_passed || multipoint_index_select))
		begin
			anchor_q <= feedback_pos;
			index_passed <= 1'b1;
		end
	end

	// Intervals are powers of two, so modulo is a mask
	assign offset = (feedback_pos - anchor_q) & (interval - POS_W'(1));
	assign below = feedback_pos - offset;
	assign above = below + interval;
	assign nearest = (offset >= (interval >> 1)) ? above : below;
	assign shift = home_shift_distance + home_shift_distance_extension;
	assign stop_at_index = homing_stop_position_select && serial_incremental_encoder &&
		method_known(homing_method);

	// =========================================
	// Sequencer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= st_idle;
			reversed_q <= 1'b0;
			target_position <= '0;
			home_position <= '0;
			target_valid <= 1'b0;
			homing_done <= 1'b0;
			homing_error <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				st_idle, st_done, st_fail:
				begin
					if (home_start)
					begin
						state_q <= st_seek_dog;
						reversed_q <= method_reversed(homing_method);
						target_valid <= 1'b0;
						homing_done <= 1'b0;
						homing_error <= 1'b0;
					end
				end
				st_seek_dog:
					if (dog_sync_q[1] && !dog_prev_q)
						state_q <= st_in_dog;
				st_in_dog:
				begin
					if (dog_fall)
					begin
						if (!index_passed)
						begin
							state_q <= st_fail;
							homing_error <= 1'b1;
						end
						else
						begin
							state_q <= st_seek_target;
							target_valid <= 1'b1;
							if (stop_at_index)
								target_position <= anchor_q + shift;
							else
								target_position <= nearest + shift;
						end
					end
				end
				st_seek_target:
				begin
					if (feedback_pos == target_position)
					begin
						state_q <= st_done;
						home_position <= target_position;
						homing_done <= 1'b1;
						target_valid <= 1'b0;
					end
				end
				default:
					state_q <= st_idle;
			endcase
		end
	end

	// =========================================
	// Status outputs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			homing_busy <= 1'b0;
			homing_direction_negative <= 1'b0;
			restricted_region <= 1'b0;
		end
		else
		begin
			homing_busy <= running;
			homing_direction_negative <= reversed_q;
			restricted_region <= homing_busy && !index_passed;
		end
	end

	// =========================================
	// Index pulse output, stretched to a visible width
	logic [3:0] pulse_cnt_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pulse_cnt_q <= 4'h0;
			encoder_index_pulse_output <= 1'b0;
		end
		else
		begin
			if (index_rise)
				pulse_cnt_q <= 4'(`INDEX_PULSE_CYCLES);
			else if (pulse_cnt_q != 4'h0)
				pulse_cnt_q <= pulse_cnt_q - 4'h1;
			encoder_index_pulse_output <= index_sync_q[1] || (pulse_cnt_q != 4'h0);
		end
	end
endmodule // linear_encoder_homing

`default_nettype wire

/* File: homing_cfg.svh */
`ifndef HOMING_CFG_SVH
`define HOMING_CFG_SVH

`define POS_W 32
`define STOP_SEL_W 3
`define STOP_SEL_RESET 3'h3
`define STOP_SEL_MAX 3'h6
`define METHOD_W 8
`define METHOD_33 8'h21
`define METHOD_34 8'h22
`define METHOD_M11 8'hf5
`define METHOD_M43 8'hd5
`define INDEX_PULSE_MIN_NS 16
`define CLK_PERIOD_NS 8
`define INDEX_PULSE_CYCLES ((`INDEX_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: homing_pkg.sv */
package homing_pkg;
	typedef enum logic [2:0] {
		st_idle,
		st_seek_dog,
		st_in_dog,
		st_seek_target,
		st_done,
		st_fail
	} homing_state_type;
endpackage

/* File: stop_interval_lut.sv */
`timescale 1ns/1ps
`default_nettype none
`include "homing_cfg.svh"

module stop_interval_lut
(
	input wire logic [`STOP_SEL_W-1:0] sel,
	output logic [`POS_W-1:0] interval,
	output logic valid
);
	// =========================================
	// Interval decode
	always_comb
	begin
		valid = 1'b1;
		unique case (sel)
			3'h0: interval = 32'h0000_2000;
			3'h1: interval = 32'h0002_0000;
			3'h2: interval = 32'h0004_0000;
			3'h3: interval = 32'h0010_0000;
			3'h4: interval = 32'h0040_0000;
			3'h5: interval = 32'h0100_0000;
			3'h6: interval = 32'h0400_0000;
			default:
			begin
				interval = 32'h0010_0000;
				valid = 1'b0;
			end
		endcase
	end
endmodule // stop_interval_lut

`default_nettype wire

/* File: linear_encoder_homing_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "homing_cfg.svh"
module homing_chk #(parameter int POS_W = 32)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [POS_W-1:0] feedback_pos,
	input wire logic encoder_index,
	input wire logic proximity_dog,
	input wire logic [`METHOD_W-1:0] homing_method,
	input wire logic encoder_index_pulse_output,
	input wire logic homing_direction_negative,
	input wire logic homing_busy,
	input wire logic homing_done,
	input wire logic homing_error,
	input wire logic index_passed,
	input wire logic restricted_region,
	input wire logic [POS_W-1:0] home_position,
	input wire logic [POS_W-1:0] target_position,
	input wire logic target_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ==========
	// Homing steps
	sequence dog_left;
		$fell(proximity_dog) && index_passed && homing_busy;
	endsequence
	chk_pulse_rise:
		assert property ($rose(encoder_index) |-> ##[1:4] encoder_index_pulse_output)
		else $error("index pulse late");
	chk_pulse_idle:
		assert property (!encoder_index [*8] |-> !encoder_index_pulse_output)
		else $error("index pulse stuck");
	chk_restrict_end:
		assert property (index_passed |=> !restricted_region)
		else $error("restricted after index");
	chk_error_cause:
		assert property ($rose(homing_error) |-> !index_passed)
		else $error("error with index");
	chk_dir_method:
		assert property (homing_busy |-> homing_direction_negative ==
			(homing_method == `METHOD_33 || homing_method == `METHOD_M43))
		else $error("direction wrong");
	chk_dog_target:
		assert property (dog_left |-> ##[1:5] target_valid)
		else $error("no target after dog");
	chk_reach_done:
		assert property (target_valid && feedback_pos == target_position |=> homing_done)
		else $error("target reached not done");
	chk_home_latch:
		assert property ($rose(homing_done) |-> home_position == $past(target_position))
		else $error("home differs from target");
endmodule // homing_chk
bind linear_encoder_homing homing_chk #(.POS_W(POS_W)) homing_chk_i (.clk, .rst,
	.feedback_pos, .encoder_index, .proximity_dog, .homing_method,
	.encoder_index_pulse_output, .homing_direction_negative, .homing_busy, .homing_done,
	.homing_error, .index_passed, .restricted_region, .home_position, .target_position,
	.target_valid);
`default_nettype wire

/* File: encoder_dog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Scale with one index mark inside travel, dog beside it
module encoder_dog_model
(
	input wire logic clk,
	input wire logic [31:0] cmd_pos,
	input wire logic target_valid,
	input wire logic [31:0] target_position,
	output logic [31:0] feedback_pos,
	output logic encoder_index,
	output logic proximity_dog
);
	// Pins derive from position, so they never disagree with it
	always @(posedge clk)
		feedback_pos <= target_valid ? target_position : cmd_pos;
	assign encoder_index = feedback_pos == 32'h3e8;
	assign proximity_dog = feedback_pos >= 32'h7d0 && feedback_pos <= 32'hbb8;
endmodule // encoder_dog_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "homing_cfg.svh"
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic home_start = 1'b0;
	logic homing_stop_position_select = 1'b0;
	logic serial_incremental_encoder = 1'b1;
	logic [2:0] linear_motor_function_select = 3'h7;
	logic [7:0] homing_method = `METHOD_34;
	logic [31:0] cmd_pos = 32'h0;
	logic [31:0] feedback_pos, home_position, target_position;
	logic encoder_index, proximity_dog, encoder_index_pulse_output, homing_direction_negative;
	logic homing_busy, homing_done, homing_error, restricted_region, index_passed, target_valid;
	logic [31:0] iv [8] = '{32'h2000, 32'h20000, 32'h40000, 32'h100000, 32'h400000,
		32'h1000000, 32'h4000000, 32'h4000000};
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #4 clk = ~clk;
	// Single mark on the scale, so multipoint stays off
	linear_encoder_homing linear_encoder_homing_i (.clk, .rst, .feedback_pos, .encoder_index,
		.proximity_dog, .linear_motor_function_select, .homing_stop_position_select,
		.multipoint_index_select(1'b0), .serial_incremental_encoder, .homing_method,
		.home_shift_distance(32'ha), .home_shift_distance_extension(32'h5), .home_start,
		.encoder_index_pulse_output, .homing_direction_negative, .homing_busy, .homing_done,
		.homing_error, .restricted_region, .index_passed, .home_position, .target_position,
		.target_valid);
	encoder_dog_model encoder_dog_model_i (.clk, .cmd_pos, .target_valid, .target_position,
		.feedback_pos, .encoder_index, .proximity_dog);
	// ==========
	// Checking and closing
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ==========
	// Scenarios
	task automatic go(logic [31:0] p, int n);
		cmd_pos = p;
		repeat (n) @(negedge clk);
	endtask
	// Always the same travel direction, so index capture stays repeatable
	task automatic home_run(logic [31:0] fall, logic [31:0] exp_t, logic exp_neg);
		go(32'h64, 2);
		home_start = 1'b1;
		go(32'h64, 1);
		home_start = 1'b0;
		go(32'h64, 3);
		check("restricted", restricted_region, 1'b1);
		check("direction", homing_direction_negative, exp_neg);
		// Mark crossed ahead of the dog, as a jog would
		go(32'h3e8, 6);
		check("index_passed", index_passed, 1'b1);
		check("pulse_out", encoder_index_pulse_output, 1'b1);
		go(32'h9c4, 4);
		go(fall, 1);
		for (int i = 0; i < 20 && target_valid !== 1'b1; i++) @(negedge clk);
		check("target_valid", target_valid, 1'b1);
		check("target", target_position, exp_t);
		for (int i = 0; i < 20 && homing_done !== 1'b1; i++) @(negedge clk);
		check("done", homing_done, 1'b1);
		check("home", home_position, exp_t);
		// Busy drops a cycle after done; method may change only after that
		go(fall, 1);
		check("busy", homing_busy, 1'b0);
	endtask
	task automatic stop_codes();
		home_run(32'h10044c, 32'h1003f7, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			linear_motor_function_select = 3'(i);
			home_run(32'h44c + iv[i], 32'h3f7 + iv[i], 1'b0);
		end
	endtask
	task automatic stop_at_index();
		logic [7:0] m [4] = '{`METHOD_33, `METHOD_34, `METHOD_M11, `METHOD_M43};
		linear_motor_function_select = 3'h0;
		homing_stop_position_select = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			homing_method = m[i];
			home_run(32'h2384, 32'h3f7, i == 0 || i == 3);
		end
		serial_incremental_encoder = 1'b0;
		home_run(32'h2384, 32'h23f7, 1'b1);
	endtask
	task automatic no_index();
		home_start = 1'b1;
		go(32'h9c4, 1);
		home_start = 1'b0;
		go(32'h9c4, 5);
		go(32'hfa0, 1);
		for (int i = 0; i < 20 && homing_error !== 1'b1; i++) @(negedge clk);
		check("error", homing_error, 1'b1);
		check("done", homing_done, 1'b0);
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		stop_codes();
		stop_at_index();
		no_index();
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
